// >>> inc/tec_pkg.sv
package tec_pkg;

  localparam int CNT_W        = 8;
  localparam int PRE_W        = 5;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [4:0] PRE_MAX = 5'h1F;
  // oscillator periods per state and states per instruction cycle
  localparam int OSC_PER_STATE   = 3;
  localparam int STATES_PER_CYC  = 10;
  localparam int OSC_PER_PRE_TICK = OSC_PER_STATE * STATES_PER_CYC;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [4:0] PRE_RST = 5'h00;

  typedef enum logic [2:0] {
    MODE_STOP  = 3'h1,
    MODE_TIMER = 3'h2,
    MODE_EVENT = 3'h4
  } mode_t;

  // one-cycle command strobes from the instruction decoder
  typedef struct packed {
    logic       loadCounterFromAcc;
    logic       readCounterToAcc;
    logic       startTimerCmd;
    logic       startEventCountCmd;
    logic       stopCountingCmd;
    logic       jumpOnOverflowFlag;
    logic       jumpIfInputHigh;
    logic       jumpIfInputLow;
    logic [7:0] acc;
  } cmd_t;

  typedef struct packed {
    logic [7:0] accData;
    logic       accValid;
    logic       jumpTaken;
    logic       jumpValid;
  } rsp_t;

endpackage

// >>> hdl/edge_sync.sv
`timescale 1ns/1ps
module edge_sync
  import tec_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic din,
  output logic      level,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

  sync_t state_q;
  sync_t state_d;

  always_comb begin
    state_d    = state_q;
    state_d.s1 = din;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= 3'h7;
    end else begin
      state_q <= state_d;
    end
  end

  assign level = state_q.s2;
  assign fall  = state_q.s3 & ~state_q.s2;

endmodule // edge_sync

// >>> hdl/timer_event_counter.sv
// Functional notes
// - 8-bit up-counter loaded from accumulator and read back into it.
// - reset leaves counter value untouched; only the load command sets it.
// - reset or stop halts counting until a start command.
// - running counter counts up, wraps past FF to zero, continues.
// - FF to 00 transition sets overflow flag, testable by a jump.
// - overflow jump clears flag; reset leaves flag alone.
// - start-timer clears prescaler before counting.
// - prescaler advances once per instruction cycle of 30 oscillator clocks.
// - 5-bit divide-by-32 prescaler; counter bumps on its wrap.
// - reading the counter does not disturb counting.
// - start-event routes input pin; each falling edge adds one.
// - no minimum edge rate; slow edges still count.
// - time base is 10 states of 3 oscillator periods each.
// - input level answers the high and low jumps.
`timescale 1ns/1ps
module timer_event_counter
  import tec_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic cycleTick,
  input  wire cmd_t cmd,
  input  wire logic countTestInput,
  output rsp_t      rsp,
  output logic      overflowFlag,
  output logic      running
);

  typedef struct packed {
    mode_t      mode;
    logic [7:0] count;
    logic [4:0] pre;
    logic       ovf;
    rsp_t       rsp;
    logic       run;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic   inLevel;
  logic   inFall;
  logic   bump;

  function automatic logic [8:0] incr8(input logic [7:0] v);
    incr8 = {1'b0, v} + 9'h001;
  endfunction

  edge_sync u_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   (countTestInput),
    .level (inLevel),
    .fall  (inFall)
  );

  // cycleTick marks one instruction cycle: 10 states x 3 osc periods
  always_comb begin
    logic [8:0] nxt;
    nxt     = incr8(state_q.count);
    state_d = state_q;
    bump    = 1'b0;
    state_d.rsp.accValid  = 1'b0;
    state_d.rsp.jumpValid = 1'b0;
    case (state_q.mode)
      MODE_TIMER: begin
        if (cycleTick) begin
          state_d.pre = state_q.pre + 5'h01;
          bump        = (state_q.pre == PRE_MAX);
        end
      end
      MODE_EVENT: begin
        bump = inFall;
      end
      MODE_STOP: begin
        bump = 1'b0;
      end
      default: begin
        state_d.mode = MODE_STOP;
      end
    endcase
    if (bump) begin
      state_d.count = nxt[7:0];
      if (state_q.count == CNT_MAX) begin
        state_d.ovf = 1'b1;
      end
    end
    if (cmd.readCounterToAcc) begin
      state_d.rsp.accData  = state_q.count;
      state_d.rsp.accValid = 1'b1;
    end
    if (cmd.jumpOnOverflowFlag) begin
      state_d.rsp.jumpTaken = state_q.ovf;
      state_d.rsp.jumpValid = 1'b1;
      if (!(bump && state_q.count == CNT_MAX)) begin
        state_d.ovf = 1'b0;
      end
    end else if (cmd.jumpIfInputHigh || cmd.jumpIfInputLow) begin
      state_d.rsp.jumpTaken = cmd.jumpIfInputHigh ? inLevel : ~inLevel;
      state_d.rsp.jumpValid = 1'b1;
    end
    if (cmd.loadCounterFromAcc) begin
      state_d.count = cmd.acc;
    end
    if (cmd.startTimerCmd) begin
      state_d.mode = MODE_TIMER;
      state_d.pre  = PRE_RST;
    end else if (cmd.startEventCountCmd) begin
      state_d.mode = MODE_EVENT;
    end else if (cmd.stopCountingCmd) begin
      state_d.mode = MODE_STOP;
    end
    state_d.run = (state_d.mode != MODE_STOP);
  end

  // count and flag stay out of the reset branch: they hold through chip reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q.mode <= MODE_STOP;
      state_q.pre  <= PRE_RST;
      state_q.rsp  <= '0;
      state_q.run  <= 1'b0;
    end else begin
      state_q.mode  <= state_d.mode;
      state_q.pre   <= state_d.pre;
      state_q.rsp   <= state_d.rsp;
      state_q.run   <= state_d.run;
      state_q.count <= state_d.count;
      state_q.ovf   <= state_d.ovf;
    end
  end

  assign rsp          = state_q.rsp;
  assign overflowFlag = state_q.ovf;
  assign running      = state_q.run;

  chk_stop_on_reset: assert property (@(posedge clock)
    $rose(nrst) |-> state_q.mode == MODE_STOP)
    else $error("mode not stopped after reset");

  chk_stop_cmd_halts: assert property (@(posedge clock) disable iff (!nrst)
    cmd.stopCountingCmd && !cmd.startTimerCmd && !cmd.startEventCountCmd
    |=> state_q.mode == MODE_STOP)
    else $error("stop command ignored");

  chk_load_value: assert property (@(posedge clock) disable iff (!nrst)
    cmd.loadCounterFromAcc |=> state_q.count == $past(cmd.acc))
    else $error("load did not take accumulator");

  chk_read_value: assert property (@(posedge clock) disable iff (!nrst)
    cmd.readCounterToAcc |=> rsp.accValid && rsp.accData == $past(state_q.count))
    else $error("read returned wrong value");

  chk_ovf_sets: assert property (@(posedge clock) disable iff (!nrst)
    state_q.count == CNT_MAX && bump && !cmd.loadCounterFromAcc
    |=> overflowFlag && state_q.count == 8'h00)
    else $error("overflow not flagged");

  chk_ovf_clears: assert property (@(posedge clock) disable iff (!nrst)
    cmd.jumpOnOverflowFlag && !bump |=> !overflowFlag && rsp.jumpTaken == $past(overflowFlag))
    else $error("overflow jump wrong");

  chk_pre_zeroed: assert property (@(posedge clock) disable iff (!nrst)
    cmd.startTimerCmd |=> state_q.pre == PRE_RST && state_q.mode == MODE_TIMER)
    else $error("prescaler not cleared");

  chk_timer_bump: assert property (@(posedge clock) disable iff (!nrst)
    state_q.mode == MODE_TIMER && cycleTick && state_q.pre != PRE_MAX
    && !cmd.loadCounterFromAcc |=> $stable(state_q.count))
    else $error("timer bumped before prescaler wrap");

  chk_event_bump: assert property (@(posedge clock) disable iff (!nrst)
    state_q.mode == MODE_EVENT && inFall && !cmd.loadCounterFromAcc
    |=> state_q.count == $past(state_q.count) + 8'h01)
    else $error("event edge not counted");

  chk_level_jump: assert property (@(posedge clock) disable iff (!nrst)
    cmd.jumpIfInputHigh && !cmd.jumpOnOverflowFlag |=> rsp.jumpTaken == $past(inLevel))
    else $error("input jump wrong");

  cov_timer_ovf: cover property (@(posedge clock) disable iff (!nrst)
    state_q.mode == MODE_TIMER && bump && state_q.count == CNT_MAX);
  cov_event_cnt: cover property (@(posedge clock) disable iff (!nrst)
    state_q.mode == MODE_EVENT && inFall);
  cov_ovf_test: cover property (@(posedge clock) disable iff (!nrst)
    cmd.jumpOnOverflowFlag && overflowFlag);

endmodule // timer_event_counter

// >>> tb/core_model.sv
`timescale 1ns/1ps
module core_model (
  input  wire logic clock,
  input  wire logic nrst,
  output logic      cycleTick
);
  logic [1:0] div;
  // instruction-cycle strobe, shortened to 4 clocks
  always @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      div = 2'h0;
      cycleTick = 1'b0;
    end else begin
      div = div + 2'h1;
      cycleTick = (div == 2'h0);
    end
  end
endmodule // core_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tec_pkg::*;
  localparam logic [7:0] LOAD = 8'h80;
  localparam logic [7:0] TGO  = 8'h20;
  localparam logic [7:0] EGO  = 8'h10;
  localparam logic [7:0] STOP = 8'h08;
  localparam logic [7:0] JOVF = 8'h04;
  localparam logic [7:0] JHI  = 8'h02;
  localparam logic [7:0] JLO  = 8'h01;
  logic clock, nrst, cycleTick, countTestInput, overflowFlag, running;
  cmd_t cmd;
  rsp_t rsp;
  int   err_count;
  int   cmp_count;
  core_model partner (.clock(clock), .nrst(nrst), .cycleTick(cycleTick));
  timer_event_counter DUT (.clock(clock), .nrst(nrst), .cycleTick(cycleTick), .cmd(cmd),
    .countTestInput(countTestInput), .rsp(rsp), .overflowFlag(overflowFlag),
    .running(running));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic [7:0] sel, input logic [7:0] a);
    @(negedge clock);
    cmd = {sel, a};
    @(negedge clock);
    cmd = '0;
  endtask
  task automatic rd(input logic [7:0] exp);
    op(8'h40, 8'h00);
    check("accValid", {7'h00, rsp.accValid}, 8'h01);
    check("accData", rsp.accData, exp);
  endtask
  task automatic jmp(input logic [7:0] sel, input logic exp);
    op(sel, 8'h00);
    check("jumpValid", {7'h00, rsp.jumpValid}, 8'h01);
    check("jumpTaken", {7'h00, rsp.jumpTaken}, {7'h00, exp});
  endtask
  task automatic ticks(input int n);
    int k;
    int t;
    k = 0;
    for (t = 0; t < 1000 && k < n; t++) begin
      @(posedge clock);
      if (cycleTick === 1'b1) k++;
    end
    if (k < n) begin
      err_count++;
      results();
    end
    @(negedge clock);
  endtask
  task automatic pin(input logic v, input int n);
    @(negedge clock);
    countTestInput = v;
    repeat (n) @(negedge clock);
  endtask
  initial begin
    err_count = 0;
    cmp_count = 0;
    nrst = 1'b0;
    cmd = '0;
    countTestInput = 1'b1;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    check("running", {7'h00, running}, 8'h00);
    op(LOAD, 8'hFE);
    rd(8'hFE);
    op(TGO, 8'h00);
    check("running", {7'h00, running}, 8'h01);
    ticks(32);
    rd(8'hFF);
    ticks(32);
    rd(8'h00);
    check("overflowFlag", {7'h00, overflowFlag}, 8'h01);
    nrst = 1'b0;
    @(negedge clock);
    nrst = 1'b1;
    check("overflowFlag", {7'h00, overflowFlag}, 8'h01);
    check("running", {7'h00, running}, 8'h00);
    rd(8'h00);
    jmp(JOVF, 1'b1);
    jmp(JOVF, 1'b0);
    op(TGO, 8'h00);
    ticks(20);
    op(TGO, 8'h00);
    ticks(31);
    rd(8'h00);
    ticks(1);
    rd(8'h01);
    op(STOP, 8'h00);
    check("running", {7'h00, running}, 8'h00);
    ticks(40);
    rd(8'h01);
    jmp(JHI, 1'b1);
    jmp(JLO, 1'b0);
    op(LOAD, 8'h00);
    op(EGO, 8'h00);
    check("running", {7'h00, running}, 8'h01);
    // falling edges 26 clocks apart, over three input periods, then one slow edge
    repeat (3) begin
      pin(1'b0, 12);
      pin(1'b1, 12);
    end
    pin(1'b0, 60);
    rd(8'h04);
    jmp(JHI, 1'b0);
    jmp(JLO, 1'b1);
    pin(1'b1, 60);
    rd(8'h04);
    results();
  end
endmodule // tb_top
